/* File: hdl/dtc_blink_gen.v */
// Purpose: Frame counter and cursor and text blink phases.
// Assumes: frame_tick is a one-cycle pulse once per displayed frame.
// Notes: Outputs are registered; visible phases are high when shown.
`timescale 1ns/1ps
`include "dtc_regs.vh"

module dtc_blink_gen (
  input wire clk,
  input wire rst,
  input wire frame_tick,
  input wire rate_sel,
  input wire blink_en,
  output reg cursor_vis_q,
  output reg text_vis_q,
  output reg [`DTC_FRAME_W-1:0] frame_q
);

  wire [`DTC_FRAME_W-1:0] frame_d;
  wire cursor_vis_d;
  wire text_vis_d;

  // Free-running counter advanced once per frame at vertical sync.
  assign frame_d = frame_tick ? frame_q + `DTC_FRAME_ONE : frame_q;

  // Slow rate: cursor 32 frames, text 64 frames; fast rate: 16 and 32.
  assign cursor_vis_d = !blink_en ? 1'b1 :
    rate_sel ? ~frame_d[`DTC_CUR_SLOW_BIT] : ~frame_d[`DTC_CUR_FAST_BIT];
  assign text_vis_d = !blink_en ? 1'b1 :
    rate_sel ? ~frame_d[`DTC_TXT_SLOW_BIT] : ~frame_d[`DTC_TXT_FAST_BIT];

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      frame_q <= {`DTC_FRAME_W{1'b0}};
      cursor_vis_q <= 1'b1;
      text_vis_q <= 1'b1;
    end else begin
      frame_q <= frame_d;
      cursor_vis_q <= cursor_vis_d;
      text_vis_q <= text_vis_d;
    end
  end

endmodule

/* File: hdl/dtc_pix_double.v */
// Purpose: Pixel fetch pacing with optional horizontal doubling.
// Assumes: The pixel source presents a pixel whenever take is high.
// Notes: A taken pixel appears one cycle later and, when doubling, twice.
`timescale 1ns/1ps
`include "dtc_regs.vh"

module dtc_pix_double (
  input wire clk,
  input wire rst,
  input wire double_en,
  input wire [`DTC_PIX_W-1:0] pix_in,
  input wire blink_in,
  input wire valid_in,
  output reg take_q,
  output reg [`DTC_PIX_W-1:0] pix_q,
  output reg blink_q,
  output reg valid_q
);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      take_q <= 1'b1;
      pix_q <= `DTC_PIX_BLANK;
      blink_q <= 1'b0;
      valid_q <= 1'b0;
    end else begin
      // Doubling takes a pixel every other cycle and shows it twice.
      take_q <= double_en ? ~take_q : 1'b1;
      if (take_q) begin
        pix_q <= pix_in;
        blink_q <= blink_in;
        valid_q <= valid_in;
      end
    end
  end

endmodule

/* File: hdl/dtc_regs.vh */
// Purpose: Named constants for the display timing configuration block.
// Assumes: Byte addresses on an 8-bit register port, 32-bit data.
// Notes: Bit positions follow the timing configuration word layout.
`ifndef DTC_REGS_VH
`define DTC_REGS_VH

// Register byte addresses.
`define DTC_ADDR_W 8
`define DTC_OFF_CFG 8'h00
`define DTC_OFF_STAT 8'h04

// Reset values.
`define DTC_CFG_RST 10'h000
`define DTC_ZERO32 32'h00000000

// Timing configuration field positions.
`define DTC_BIT_RATE 16
`define DTC_BIT_PXDBL 15
`define DTC_BIT_ILACE 14
`define DTC_BIT_PLANAR 13
`define DTC_BIT_CENTER 12
`define DTC_BIT_PVINV 11
`define DTC_BIT_PHINV 10
`define DTC_BIT_CVINV 9
`define DTC_BIT_CHINV 8
`define DTC_BIT_BLINK 7
`define DTC_CFG_LSB 7
`define DTC_CFG_MSB 16
`define DTC_CFG_W 10

// Status register field positions.
`define DTC_ST_FRAME_MSB 5
`define DTC_ST_FRAME_LSB 0
`define DTC_ST_CURSOR 8
`define DTC_ST_TEXT 9
`define DTC_ST_ODD 12

// Frame counter and blink phase bits.
`define DTC_FRAME_W 6
`define DTC_FRAME_ONE 6'h01
`define DTC_CUR_SLOW_BIT 4
`define DTC_CUR_FAST_BIT 3
`define DTC_TXT_SLOW_BIT 5
`define DTC_TXT_FAST_BIT 4

// Pixel path.
`define DTC_PIX_W 8
`define DTC_PIX_BLANK 8'h00

// Sync indices in the polarity generate loop.
`define DTC_NSYNC 4
`define DTC_SY_CRT_H 0
`define DTC_SY_CRT_V 1
`define DTC_SY_PNL_H 2
`define DTC_SY_PNL_V 3

`endif

/* File: hdl/dtc_timing_cfg.v */
// Purpose: Display timing configuration bits and their effect on the display outputs.
// Assumes: One pixel clock SYS_CLK; timing inputs come from the timing generator.
// Notes: Registers are reached over a plain port with read data one cycle later.
`timescale 1ns/1ps
`include "dtc_regs.vh"

module dtc_timing_cfg (
  input wire SYS_CLK,
  input wire RST,
  input wire [`DTC_ADDR_W-1:0] REG_ADDR,
  input wire [31:0] REG_WDATA,
  input wire REG_WR,
  input wire REG_RD,
  output reg [31:0] REG_RDATA,
  input wire TG_HSYNC,
  input wire TG_VSYNC,
  input wire TG_ACTIVE,
  input wire TG_BORDER,
  input wire [`DTC_PIX_W-1:0] PIX_IN,
  input wire PIX_IN_BLINK,
  input wire PIX_IN_VALID,
  input wire CURSOR_HIT,
  output wire PIX_TAKE,
  output reg [`DTC_PIX_W-1:0] PIX_OUT,
  output reg PIX_OUT_VALID,
  output reg CURSOR_SHOW,
  output reg CRT_HORIZONTAL_SYNC_OUT,
  output reg CRT_VERTICAL_SYNC_OUT,
  output reg PANEL_HSYNC,
  output reg PANEL_VSYNC,
  output reg PANEL_DISPLAY_QUALIFIER,
  output reg INTERLACE_EN,
  output reg ODD_FIELD,
  output reg PLANAR_MODE,
  output reg PIXEL_DOUBLE_EN
);

  // Stored configuration bits, 16 down to 7.
  reg [`DTC_CFG_W-1:0] cfg_q;
  reg [`DTC_CFG_W-1:0] cfg_d;

  // Decoded configuration fields.
  wire blink_rate_select;
  wire pixel_double_en;
  wire interlace_scan_en;
  wire planar_mode_en;
  wire panel_center_en;
  wire panel_vsync_invert;
  wire panel_hsync_invert;
  wire crt_vertical_sync_out_invert;
  wire crt_horizontal_sync_out_invert;
  wire blink_enable_bit;

  // Vertical sync edge detection for the frame tick.
  reg vsync_prev_q;
  wire frame_tick;

  // Interlace field tracking.
  reg odd_field_d;

  // Blink phases and frame counter.
  wire cursor_vis;
  wire text_vis;
  wire [`DTC_FRAME_W-1:0] frame_cnt;

  // Doubler output stage.
  wire [`DTC_PIX_W-1:0] dbl_pix;
  wire dbl_blink;
  wire dbl_valid;

  // Register read path.
  reg [31:0] rdata_d;
  reg [31:0] cfg_word;
  reg [31:0] stat_word;

  // Sync sources and polarity controls, indexed by the sync loop.
  wire [`DTC_NSYNC-1:0] sync_raw;
  wire [`DTC_NSYNC-1:0] sync_inv;
  wire [`DTC_NSYNC-1:0] sync_d;
  reg [`DTC_NSYNC-1:0] sync_q;

  // Pixel stage next values.
  reg [`DTC_PIX_W-1:0] pix_d;
  reg cursor_show_d;
  reg qual_d;

  // Applies an inversion control to a sync level that is high in sync.
  function sync_level;
    input raw;
    input inv;
    begin
      sync_level = raw ^ inv;
    end
  endfunction

  // Compares a register address against one mapped offset.
  function addr_hit;
    input [`DTC_ADDR_W-1:0] addr;
    input [`DTC_ADDR_W-1:0] off;
    begin
      addr_hit = (addr == off);
    end
  endfunction

  // Field decode from the stored configuration.
  assign blink_rate_select = cfg_q[`DTC_BIT_RATE - `DTC_CFG_LSB];
  assign pixel_double_en = cfg_q[`DTC_BIT_PXDBL - `DTC_CFG_LSB];
  assign interlace_scan_en = cfg_q[`DTC_BIT_ILACE - `DTC_CFG_LSB];
  assign planar_mode_en = cfg_q[`DTC_BIT_PLANAR - `DTC_CFG_LSB];
  assign panel_center_en = cfg_q[`DTC_BIT_CENTER - `DTC_CFG_LSB];
  assign panel_vsync_invert = cfg_q[`DTC_BIT_PVINV - `DTC_CFG_LSB];
  assign panel_hsync_invert = cfg_q[`DTC_BIT_PHINV - `DTC_CFG_LSB];
  assign crt_vertical_sync_out_invert = cfg_q[`DTC_BIT_CVINV - `DTC_CFG_LSB];
  assign crt_horizontal_sync_out_invert = cfg_q[`DTC_BIT_CHINV - `DTC_CFG_LSB];
  assign blink_enable_bit = cfg_q[`DTC_BIT_BLINK - `DTC_CFG_LSB];

  // Configuration write; only bits 16 down to 7 are stored.
  always @* begin
    cfg_d = cfg_q;
    if (REG_WR && addr_hit(REG_ADDR, `DTC_OFF_CFG)) begin
      cfg_d = REG_WDATA[`DTC_CFG_MSB:`DTC_CFG_LSB];
    end
  end

  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      cfg_q <= `DTC_CFG_RST;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // Read words; unstored and reserved bits read as zero.
  always @* begin
    cfg_word = `DTC_ZERO32;
    cfg_word[`DTC_CFG_MSB:`DTC_CFG_LSB] = cfg_q;
  end

  always @* begin
    stat_word = `DTC_ZERO32;
    stat_word[`DTC_ST_FRAME_MSB:`DTC_ST_FRAME_LSB] = frame_cnt;
    stat_word[`DTC_ST_CURSOR] = cursor_vis;
    stat_word[`DTC_ST_TEXT] = text_vis;
    stat_word[`DTC_ST_ODD] = ODD_FIELD;
  end

  // Read data stand only in the cycle after the read strobe.
  always @* begin
    rdata_d = `DTC_ZERO32;
    if (REG_RD) begin
      if (addr_hit(REG_ADDR, `DTC_OFF_CFG)) begin
        rdata_d = cfg_word;
      end else if (addr_hit(REG_ADDR, `DTC_OFF_STAT)) begin
        rdata_d = stat_word;
      end else begin
        rdata_d = `DTC_ZERO32;
      end
    end
  end

  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      REG_RDATA <= `DTC_ZERO32;
    end else begin
      REG_RDATA <= rdata_d;
    end
  end

  // One tick per frame on the rising edge of the raw vertical sync.
  assign frame_tick = TG_VSYNC & ~vsync_prev_q;

  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      vsync_prev_q <= 1'b0;
    end else begin
      vsync_prev_q <= TG_VSYNC;
    end
  end

  // Field alternates each frame in interlaced scan, stays even otherwise.
  always @* begin
    odd_field_d = ODD_FIELD;
    if (!interlace_scan_en) begin
      odd_field_d = 1'b0;
    end else if (frame_tick) begin
      odd_field_d = ~ODD_FIELD;
    end
  end

  // Mode outputs that other display logic follows.
  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      INTERLACE_EN <= 1'b0;
    end else begin
      INTERLACE_EN <= interlace_scan_en;
    end
  end

  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      ODD_FIELD <= 1'b0;
    end else begin
      ODD_FIELD <= odd_field_d;
    end
  end

  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      PLANAR_MODE <= 1'b0;
    end else begin
      PLANAR_MODE <= planar_mode_en;
    end
  end

  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      PIXEL_DOUBLE_EN <= 1'b0;
    end else begin
      PIXEL_DOUBLE_EN <= pixel_double_en;
    end
  end

  // Sync sources and their polarity controls.
  assign sync_raw[`DTC_SY_CRT_H] = TG_HSYNC;
  assign sync_raw[`DTC_SY_CRT_V] = TG_VSYNC;
  assign sync_raw[`DTC_SY_PNL_H] = TG_HSYNC;
  assign sync_raw[`DTC_SY_PNL_V] = TG_VSYNC;
  assign sync_inv[`DTC_SY_CRT_H] = crt_horizontal_sync_out_invert;
  assign sync_inv[`DTC_SY_CRT_V] = crt_vertical_sync_out_invert;
  assign sync_inv[`DTC_SY_PNL_H] = panel_hsync_invert;
  assign sync_inv[`DTC_SY_PNL_V] = panel_vsync_invert;

  // Each sync output idles at the polarity bit and pulses to its opposite.
  genvar gi;
  generate
    for (gi = 0; gi < `DTC_NSYNC; gi = gi + 1) begin : g_sync
      assign sync_d[gi] = sync_level(sync_raw[gi], sync_inv[gi]);
      always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
          sync_q[gi] <= 1'b0;
        end else begin
          sync_q[gi] <= sync_d[gi];
        end
      end
    end
  endgenerate

  // Second stage aligns syncs with the pixel path.
  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      CRT_HORIZONTAL_SYNC_OUT <= 1'b0;
      CRT_VERTICAL_SYNC_OUT <= 1'b0;
      PANEL_HSYNC <= 1'b0;
      PANEL_VSYNC <= 1'b0;
    end else begin
      CRT_HORIZONTAL_SYNC_OUT <= sync_q[`DTC_SY_CRT_H];
      CRT_VERTICAL_SYNC_OUT <= sync_q[`DTC_SY_CRT_V];
      PANEL_HSYNC <= sync_q[`DTC_SY_PNL_H];
      PANEL_VSYNC <= sync_q[`DTC_SY_PNL_V];
    end
  end

  // Blink phase generation.
  dtc_blink_gen u_blink (
    .clk(SYS_CLK),
    .rst(RST),
    .frame_tick(frame_tick),
    .rate_sel(blink_rate_select),
    .blink_en(blink_enable_bit),
    .cursor_vis_q(cursor_vis),
    .text_vis_q(text_vis),
    .frame_q(frame_cnt)
  );

  // Pixel fetch pacing and doubling; software halves the fetched line.
  dtc_pix_double u_double (
    .clk(SYS_CLK),
    .rst(RST),
    .double_en(pixel_double_en),
    .pix_in(PIX_IN),
    .blink_in(PIX_IN_BLINK),
    .valid_in(PIX_IN_VALID),
    .take_q(PIX_TAKE),
    .pix_q(dbl_pix),
    .blink_q(dbl_blink),
    .valid_q(dbl_valid)
  );

  // Blink-marked pixels are blanked in the hidden text phase.
  always @* begin
    pix_d = dbl_pix;
    if (dbl_blink && !text_vis) begin
      pix_d = `DTC_PIX_BLANK;
    end
  end

  // Cursor shows only in its visible phase.
  always @* begin
    cursor_show_d = CURSOR_HIT & cursor_vis;
  end

  // Panel qualifier covers border too when centering is on.
  always @* begin
    if (panel_center_en) begin
      qual_d = TG_ACTIVE | TG_BORDER;
    end else begin
      qual_d = TG_ACTIVE;
    end
  end

  reg qual_q;

  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      qual_q <= 1'b0;
      PANEL_DISPLAY_QUALIFIER <= 1'b0;
    end else begin
      qual_q <= qual_d;
      PANEL_DISPLAY_QUALIFIER <= qual_q;
    end
  end

  // Output pixel stage.
  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      PIX_OUT <= `DTC_PIX_BLANK;
      PIX_OUT_VALID <= 1'b0;
      CURSOR_SHOW <= 1'b0;
    end else begin
      PIX_OUT <= pix_d;
      PIX_OUT_VALID <= dbl_valid;
      CURSOR_SHOW <= cursor_show_d;
    end
  end

endmodule

/* File: test/dtc_display_model.sv */
// Purpose: Monitor model that counts frames on its vertical sync input.
// Assumes: The monitor is told which sync polarity to expect.
// Notes: A frame starts at the leading edge of the sync pulse.
`timescale 1ns/1ps
module dtc_display_model (
  input wire clk,
  input wire rst,
  input wire vsync_in,
  input wire vsync_inv,
  output reg [15:0] frames_q
);
  reg prev_q;
  wire pulse = vsync_in ^ vsync_inv;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_q <= 1'b1;
      frames_q <= 16'h0000;
    end else begin
      prev_q <= pulse;
      if (pulse && !prev_q) begin
        frames_q <= frames_q + 16'h0001;
      end
    end
  end
endmodule

/* File: test/dtc_timing_cfg_assertions.sv */
// Purpose: Concurrent checks on the timing configuration outputs.
// Assumes: The configuration word sits at byte address 8'h00.
// Notes: Checks wait for three quiet edges after reset or any write.
`timescale 1ns/1ps
module dtc_timing_cfg_assertions (
  input wire SYS_CLK,
  input wire RST,
  input wire [7:0] REG_ADDR,
  input wire [31:0] REG_WDATA,
  input wire REG_WR,
  input wire TG_HSYNC,
  input wire TG_VSYNC,
  input wire TG_ACTIVE,
  input wire TG_BORDER,
  input wire PIX_TAKE,
  input wire CRT_HORIZONTAL_SYNC_OUT,
  input wire CRT_VERTICAL_SYNC_OUT,
  input wire PANEL_HSYNC,
  input wire PANEL_VSYNC,
  input wire PANEL_DISPLAY_QUALIFIER,
  input wire INTERLACE_EN,
  input wire ODD_FIELD,
  input wire PLANAR_MODE,
  input wire PIXEL_DOUBLE_EN
);
  reg [16:7] cfg_q;
  reg [1:0] quiet_q;
  wire quiet = quiet_q == 2'h3;
  // Shadow of the configuration bits and a settle counter.
  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      cfg_q <= 10'h000;
      quiet_q <= 2'h0;
    end else if (REG_WR) begin
      quiet_q <= 2'h0;
      if (REG_ADDR == 8'h00) begin
        cfg_q <= REG_WDATA[16:7];
      end
    end else if (!quiet) begin
      quiet_q <= quiet_q + 2'h1;
    end
  end
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  crt_horizontal_sync_out_pol_a: assert property (quiet |->
    CRT_HORIZONTAL_SYNC_OUT == ($past(TG_HSYNC, 2) ^ cfg_q[8]))
    else $error("Crt_horizontal_sync_out polarity wrong");
  crt_vertical_sync_out_pol_a: assert property (quiet |->
    CRT_VERTICAL_SYNC_OUT == ($past(TG_VSYNC, 2) ^ cfg_q[9]))
    else $error("Crt_vertical_sync_out polarity wrong");
  panel_hsync_pol_a: assert property (quiet |->
    PANEL_HSYNC == ($past(TG_HSYNC, 2) ^ cfg_q[10]))
    else $error("Panel hsync polarity wrong");
  panel_vsync_pol_a: assert property (quiet |->
    PANEL_VSYNC == ($past(TG_VSYNC, 2) ^ cfg_q[11]))
    else $error("Panel vsync polarity wrong");
  center_qual_a: assert property (quiet |->
    PANEL_DISPLAY_QUALIFIER == ($past(TG_ACTIVE, 2) | ($past(TG_BORDER, 2) & cfg_q[12])))
    else $error("Panel qualifier wrong");
  interlace_mode_a: assert property (quiet |->
    INTERLACE_EN == cfg_q[14] && (cfg_q[14] || !ODD_FIELD))
    else $error("Interlace outputs wrong");
  single_take_a: assert property (quiet && !cfg_q[15] |-> PIX_TAKE)
    else $error("Undoubled take gap");
  double_take_a: assert property (quiet && cfg_q[15] |=> PIX_TAKE != $past(PIX_TAKE))
    else $error("Doubled take not alternating");
  mode_copy_a: assert property (quiet |->
    PIXEL_DOUBLE_EN == cfg_q[15] && PLANAR_MODE == cfg_q[13])
    else $error("Mode copies wrong");
endmodule
bind dtc_timing_cfg dtc_timing_cfg_assertions chk (.SYS_CLK, .RST, .REG_ADDR,
  .REG_WDATA, .REG_WR, .TG_HSYNC, .TG_VSYNC, .TG_ACTIVE, .TG_BORDER, .PIX_TAKE,
  .CRT_HORIZONTAL_SYNC_OUT, .CRT_VERTICAL_SYNC_OUT, .PANEL_HSYNC, .PANEL_VSYNC,
  .PANEL_DISPLAY_QUALIFIER, .INTERLACE_EN, .ODD_FIELD, .PLANAR_MODE, .PIXEL_DOUBLE_EN);

/* File: test/dtc_timing_cfg_bench.sv */
// Purpose: Self-checking bench for the timing configuration block.
// Assumes: Configuration at 8'h00, status at 8'h04.
// Notes: Frame ticks are tracked by the bench to predict blink phases.
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests = n_tests + 1; if ((a) !== (b)) begin \
  fail_count = fail_count + 1; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module dtc_timing_cfg_bench;
  reg SYS_CLK = 1'b0;
  reg RST = 1'b1;
  reg [7:0] REG_ADDR = 8'h00;
  reg [31:0] REG_WDATA = 32'h00000000;
  reg REG_WR = 1'b0, REG_RD = 1'b0, TG_HSYNC = 1'b0, TG_VSYNC = 1'b0;
  reg TG_ACTIVE = 1'b0, TG_BORDER = 1'b0, PIX_IN_BLINK = 1'b1, PIX_IN_VALID = 1'b1;
  reg CURSOR_HIT = 1'b1;
  reg [7:0] PIX_IN = 8'h5a;
  wire [31:0] REG_RDATA;
  wire [7:0] PIX_OUT;
  wire PIX_TAKE, PIX_OUT_VALID, CURSOR_SHOW, CRT_HORIZONTAL_SYNC_OUT, CRT_VERTICAL_SYNC_OUT;
  wire PANEL_HSYNC, PANEL_VSYNC, PANEL_DISPLAY_QUALIFIER, INTERLACE_EN, ODD_FIELD;
  wire PLANAR_MODE, PIXEL_DOUBLE_EN;
  wire [3:0] syncs;
  assign syncs = {PANEL_VSYNC, PANEL_HSYNC, CRT_VERTICAL_SYNC_OUT, CRT_HORIZONTAL_SYNC_OUT};
  wire [15:0] frames;
  integer fail_count = 0, n_tests = 0, i, j, takes;
  reg [4:0] k;
  reg [5:0] ticks = 6'h00;
  reg [15:0] f0;
  reg [1:0] vis;
  always #50 SYS_CLK = ~SYS_CLK;
  dtc_timing_cfg dut (.SYS_CLK, .RST, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA,
    .TG_HSYNC, .TG_VSYNC, .TG_ACTIVE, .TG_BORDER, .PIX_IN, .PIX_IN_BLINK, .PIX_IN_VALID,
    .CURSOR_HIT, .PIX_TAKE, .PIX_OUT, .PIX_OUT_VALID, .CURSOR_SHOW, .CRT_HORIZONTAL_SYNC_OUT,
    .CRT_VERTICAL_SYNC_OUT, .PANEL_HSYNC, .PANEL_VSYNC, .PANEL_DISPLAY_QUALIFIER,
    .INTERLACE_EN, .ODD_FIELD, .PLANAR_MODE, .PIXEL_DOUBLE_EN);
  dtc_display_model mon (.clk(SYS_CLK), .rst(RST), .vsync_in(CRT_VERTICAL_SYNC_OUT),
    .vsync_inv(1'b1), .frames_q(frames));
  task tally_and_finish;
    begin
      if (fail_count == 0 && n_tests > 0) begin
        $display("Finished cleanly");
      end else begin
        $display("Finished with errors");
      end
      $finish;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge SYS_CLK);
      REG_ADDR <= a;
      REG_WDATA <= d;
      REG_WR <= 1'b1;
      @(posedge SYS_CLK);
      REG_WR <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      @(posedge SYS_CLK);
      REG_ADDR <= a;
      REG_RD <= 1'b1;
      @(posedge SYS_CLK);
      REG_RD <= 1'b0;
      #1;
      `CHK(REG_RDATA, e)
    end
  endtask
  task settle;
    begin
      repeat (4) @(posedge SYS_CLK);
      #1;
    end
  endtask
  // One frame: a vertical sync pulse three cycles long.
  task vs;
    begin
      @(posedge SYS_CLK);
      TG_VSYNC <= 1'b1;
      ticks = ticks + 6'h01;
      repeat (3) @(posedge SYS_CLK);
      TG_VSYNC <= 1'b0;
      settle;
    end
  endtask
  initial begin
    #2000000;
    fail_count = fail_count + 1;
    tally_and_finish;
  end
  initial begin
    repeat (8) @(posedge SYS_CLK);
    RST <= 1'b0;
    rd(8'h00, 32'h00000000);
    wr(8'h08, 32'hffffffff);
    rd(8'h08, 32'h00000000);
    rd(8'h00, 32'h00000000);
    wr(8'h00, 32'hffffffff);
    rd(8'h00, 32'h0001ff80);
    @(posedge SYS_CLK);
    #1;
    `CHK(REG_RDATA, 32'h00000000)
    for (k = 0; k < 16; k = k + 1) begin
      wr(8'h00, {20'h00000, k[3:0], 8'h00});
      for (j = 0; j < 2; j = j + 1) begin
        @(posedge SYS_CLK);
        TG_HSYNC <= j[0];
        TG_VSYNC <= j[0];
        ticks = ticks + {5'h00, j[0]};
        settle;
        `CHK(syncs, {4{j[0]}} ^ k[3:0])
      end
      @(posedge SYS_CLK);
      TG_HSYNC <= 1'b0;
      TG_VSYNC <= 1'b0;
    end
    for (k = 0; k < 8; k = k + 1) begin
      wr(8'h00, {19'h00000, k[2], 12'h000});
      TG_ACTIVE <= k[1];
      TG_BORDER <= k[0];
      CURSOR_HIT <= k[0];
      settle;
      `CHK(PANEL_DISPLAY_QUALIFIER, k[1] | (k[2] & k[0]))
      `CHK(CURSOR_SHOW, k[0])
    end
    for (j = 0; j < 2; j = j + 1) begin
      wr(8'h00, j[0] ? 32'h00008000 : 32'h00000000);
      PIX_IN_VALID <= j[0];
      settle;
      takes = 0;
      repeat (8) begin
        @(posedge SYS_CLK);
        #1;
        takes = takes + PIX_TAKE;
      end
      `CHK(takes, j[0] ? 4 : 8)
      `CHK({PIXEL_DOUBLE_EN, PIX_OUT_VALID, PIX_OUT}, {j[0], j[0], 8'h5a})
    end
    // Interlace and planar mode are set together; the field starts even.
    wr(8'h00, 32'h00006000);
    settle;
    `CHK({INTERLACE_EN, PLANAR_MODE, ODD_FIELD}, 3'b110)
    vs;
    `CHK(ODD_FIELD, 1'b1)
    vs;
    `CHK(ODD_FIELD, 1'b0)
    for (j = 0; j < 3; j = j + 1) begin
      wr(8'h00, j == 0 ? 32'h00000280 : (j == 1 ? 32'h00010280 : 32'h00000200));
      settle;
      f0 = frames;
      for (i = 0; i < 64; i = i + 1) begin
        vs;
        vis = j == 0 ? ~ticks[4:3] : (j == 1 ? ~ticks[5:4] : 2'b11);
        rd(8'h04, {22'h000000, vis, 2'b00, ticks});
        `CHK({CURSOR_SHOW, PIX_OUT}, {vis[0], vis[1] ? 8'h5a : 8'h00})
      end
      `CHK(frames - f0, 16'h0040)
    end
    tally_and_finish;
  end
endmodule
